/* swcfg_cfg.svh */
// register offsets, field positions and reset values of the selective-wake register set
`ifndef SWCFG_CFG_SVH
`define SWCFG_CFG_SVH

// register offsets on the serial register port (7-bit address)
`define SWCFG_ADDR_CTRL      7'h20
`define SWCFG_ADDR_QUANTA    7'h21
`define SWCFG_ADDR_SAMPLE    7'h22
`define SWCFG_ADDR_ID_HIGH   7'h23
`define SWCFG_ADDR_ID_MIDH   7'h24
`define SWCFG_ADDR_ID_MIDL   7'h25
`define SWCFG_ADDR_ID_LOW    7'h26

// reset values after power-on or soft reset
`define SWCFG_RST_CTRL       8'h00
`define SWCFG_RST_QUANTA     8'ha0
`define SWCFG_RST_SAMPLE     6'h33
`define SWCFG_RST_ID_BYTE    8'h00
`define SWCFG_RST_ID_LOW     5'h00

// control register field positions
`define SWCFG_CTRL_TRIM_BIT  7
`define SWCFG_CTRL_UNLK_HI   6
`define SWCFG_CTRL_UNLK_LO   5
`define SWCFG_CTRL_TOIE_BIT  4
`define SWCFG_CTRL_VALID_BIT 0
`define SWCFG_UNLOCK_CODE    2'h3

// lowest identifier register field positions
`define SWCFG_IDL_ID_HI      6
`define SWCFG_IDL_ID_LO      2
`define SWCFG_IDL_RTR_BIT    1
`define SWCFG_IDL_IDE_BIT    0

// identifier layout: standard identifier sits in bits 28..18
`define SWCFG_STD_ID_HI      28
`define SWCFG_STD_ID_LO      18

`endif

/* swcfg_pkg.sv */
// types shared by the selective-wake configuration register set
package swcfg_pkg;
  typedef logic [7:0]  swcfg_byte_type;
  typedef logic [6:0]  swcfg_addr_type;
  typedef logic [28:0] swcfg_id_type;
  typedef logic [5:0]  swcfg_sample_type;
endpackage

/* swcfg_regs.sv */
// selective-wake configuration register set with arming, trim gating and wake-id compare
// Summary of operation
// - host validates setup, sets valid flag; selective wake armed only while it is set
// - valid flag self-clears on wake event, power-on and any config data change
// - in stop mode any transceiver or wake config write forces valid flag to zero
// - calibration unlock counts only when the two-bit field holds binary 11
// - unlock value also permits low-power receiver option writes, else they are blocked
// - trim mode bit one enables oscillator calibration, zero disables it
// - calibration uses the bus transmit-data pin as the trim reference
// - time-out interrupt enable zero masks bus time-out interrupt, one signals it
// - bus time-out flag only updates while selective-wake enable is set
// - three unused control bits between enable and valid flag read as zero
// - eight-bit quanta-per-bit field, resets to 1010 0000
// - six-bit sample point fraction, upper two bits reserved, resets to 0011 0011
// - 29-bit wake id split over four registers, low bits at positions 6..2
// - standard-format wake id lives in bits 18..28 and only those are compared
// - remote flag zero means data frame, one means remote request
// - extension flag zero selects 11-bit id, one selects 29-bit id
// - timing and id registers load defaults on power-on or soft reset, kept on restart
`timescale 1ns/10ps
`default_nettype none
`include "swcfg_cfg.svh"

module swcfg_regs (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      soft_reset_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire swcfg_pkg::swcfg_addr_type reg_addr_i,
  input  wire swcfg_pkg::swcfg_byte_type reg_wdata_i,
  output logic                           reg_rdata_valid_o,
  output swcfg_pkg::swcfg_byte_type      reg_rdata_o,
  input  wire logic                      stop_mode_i,
  input  wire logic                      bus_cfg_wr_i,
  input  wire logic                      wake_event_i,
  input  wire logic                      selective_wake_enable_i,
  input  wire logic                      bus_timeout_event_i,
  input  wire logic                      bus_timeout_clear_i,
  input  wire logic                      bus_transmit_data_pin_i,
  input  wire logic                      opt_wr_req_i,
  input  wire logic                      rx_frame_valid_i,
  input  wire swcfg_pkg::swcfg_id_type   rx_id_i,
  input  wire logic                      rx_ide_i,
  input  wire logic                      rx_rtr_i,
  output logic                           wake_config_valid_o,
  output logic                           selective_wake_armed_o,
  output logic                           osc_trim_active_o,
  output logic                           trim_ref_o,
  output logic                           opt_wr_allow_o,
  output logic                           bus_timeout_flag_o,
  output logic                           irq_o,
  output swcfg_pkg::swcfg_byte_type      quanta_per_bit_o,
  output swcfg_pkg::swcfg_sample_type    sample_point_o,
  output swcfg_pkg::swcfg_id_type        wake_id_o,
  output logic                           wake_rtr_o,
  output logic                           wake_ide_o,
  output logic                           id_match_o
);
  import swcfg_pkg::*;

  // control reset byte held as a constant, so its fields can be selected
  localparam swcfg_byte_type ctrl_reset_val = `SWCFG_RST_CTRL;

  // stored fields
  logic             trim_mode_reg;
  logic [1:0]       unlock_reg;
  logic             toie_reg;
  logic             valid_reg;
  swcfg_byte_type   quanta_reg;
  swcfg_sample_type sample_reg;
  swcfg_byte_type   id_high_reg;
  swcfg_byte_type   id_midh_reg;
  swcfg_byte_type   id_midl_reg;
  logic [4:0]       id_low_reg;
  logic             rtr_reg;
  logic             ide_reg;
  logic             to_flag_reg;

  // decoded strobes
  logic wr_ctrl;
  logic wr_data;
  logic unlocked;
  logic defaults;
  swcfg_id_type id_full;
  swcfg_id_type cmp_mask;
  swcfg_id_type id_bit_ok;
  logic         valid_next;

  assign wr_ctrl  = reg_wr_i && (reg_addr_i == `SWCFG_ADDR_CTRL);
  // any write to the timing or id bytes counts as a config data change
  assign wr_data  = reg_wr_i && (reg_addr_i >= `SWCFG_ADDR_QUANTA)
                             && (reg_addr_i <= `SWCFG_ADDR_ID_LOW);
  assign unlocked = (unlock_reg == `SWCFG_UNLOCK_CODE);
  assign defaults = !rst_b_i || soft_reset_i;
  assign id_full  = {id_high_reg, id_midh_reg, id_midl_reg, id_low_reg};

  // oscillator trim mode bit
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      trim_mode_reg <= ctrl_reset_val[`SWCFG_CTRL_TRIM_BIT];
    end else if (wr_ctrl) begin
      trim_mode_reg <= reg_wdata_i[`SWCFG_CTRL_TRIM_BIT];
    end
  end

  // unlock field; only the full code opens trim and option writes
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      unlock_reg <= ctrl_reset_val[`SWCFG_CTRL_UNLK_HI:`SWCFG_CTRL_UNLK_LO];
    end else if (wr_ctrl) begin
      unlock_reg <= reg_wdata_i[`SWCFG_CTRL_UNLK_HI:`SWCFG_CTRL_UNLK_LO];
    end
  end

  // time-out interrupt enable bit
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      toie_reg <= ctrl_reset_val[`SWCFG_CTRL_TOIE_BIT];
    end else if (wr_ctrl) begin
      toie_reg <= reg_wdata_i[`SWCFG_CTRL_TOIE_BIT];
    end
  end

  // valid flag next value: hardware clears beat a host set in the same cycle,
  // so a wake or a config change is never hidden behind a stale setup
  always_comb begin
    valid_next = valid_reg;
    if (wake_event_i || wr_data) begin
      valid_next = 1'b0;
    end else if (stop_mode_i && (wr_ctrl || bus_cfg_wr_i)) begin
      valid_next = 1'b0;
    end else if (wr_ctrl) begin
      valid_next = reg_wdata_i[`SWCFG_CTRL_VALID_BIT];
    end
  end

  // valid flag register; power-on and soft reset clear it
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      valid_reg <= ctrl_reset_val[`SWCFG_CTRL_VALID_BIT];
    end else begin
      valid_reg <= valid_next;
    end
  end

  // quanta per bit, kept across restart since only reset loads it
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      quanta_reg <= `SWCFG_RST_QUANTA;
    end else if (reg_wr_i && (reg_addr_i == `SWCFG_ADDR_QUANTA)) begin
      quanta_reg <= reg_wdata_i;
    end
  end

  // sample point; the two reserved top bits are simply not stored
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      sample_reg <= `SWCFG_RST_SAMPLE;
    end else if (reg_wr_i && (reg_addr_i == `SWCFG_ADDR_SAMPLE)) begin
      sample_reg <= reg_wdata_i[5:0];
    end
  end

  // wake frame identifier and flags
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      id_high_reg <= `SWCFG_RST_ID_BYTE;
      id_midh_reg <= `SWCFG_RST_ID_BYTE;
      id_midl_reg <= `SWCFG_RST_ID_BYTE;
      id_low_reg  <= `SWCFG_RST_ID_LOW;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SWCFG_ADDR_ID_HIGH: begin
          id_high_reg <= reg_wdata_i;
        end
        `SWCFG_ADDR_ID_MIDH: begin
          id_midh_reg <= reg_wdata_i;
        end
        `SWCFG_ADDR_ID_MIDL: begin
          id_midl_reg <= reg_wdata_i;
        end
        `SWCFG_ADDR_ID_LOW: begin
          id_low_reg <= reg_wdata_i[`SWCFG_IDL_ID_HI:`SWCFG_IDL_ID_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // remote and extension flags, sharing the lowest identifier byte
  always_ff @(posedge sys_clk_i) begin
    if (defaults) begin
      rtr_reg <= 1'b0;
      ide_reg <= 1'b0;
    end else if (reg_wr_i && (reg_addr_i == `SWCFG_ADDR_ID_LOW)) begin
      rtr_reg <= reg_wdata_i[`SWCFG_IDL_RTR_BIT];
      ide_reg <= reg_wdata_i[`SWCFG_IDL_IDE_BIT];
    end
  end

  // time-out flag; event set wins over clear, frozen while wake disabled
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      to_flag_reg <= 1'b0;
    end else if (selective_wake_enable_i) begin
      if (bus_timeout_event_i) begin
        to_flag_reg <= 1'b1;
      end else if (bus_timeout_clear_i) begin
        to_flag_reg <= 1'b0;
      end
    end
  end

  // read path; unmapped and reserved bits answer zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_valid_o <= 1'b0;
      reg_rdata_o       <= 8'h00;
    end else begin
      reg_rdata_valid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `SWCFG_ADDR_CTRL: begin
            reg_rdata_o <= {trim_mode_reg, unlock_reg, toie_reg, 3'h0, valid_reg};
          end
          `SWCFG_ADDR_QUANTA: begin
            reg_rdata_o <= quanta_reg;
          end
          `SWCFG_ADDR_SAMPLE: begin
            reg_rdata_o <= {2'h0, sample_reg};
          end
          `SWCFG_ADDR_ID_HIGH: begin
            reg_rdata_o <= id_high_reg;
          end
          `SWCFG_ADDR_ID_MIDH: begin
            reg_rdata_o <= id_midh_reg;
          end
          `SWCFG_ADDR_ID_MIDL: begin
            reg_rdata_o <= id_midl_reg;
          end
          `SWCFG_ADDR_ID_LOW: begin
            reg_rdata_o <= {1'b0, id_low_reg, rtr_reg, ide_reg};
          end
          default: begin
            reg_rdata_o <= 8'h00;
          end
        endcase
      end
    end
  end

  // valid view and arming, registered one cycle behind the flag
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wake_config_valid_o    <= 1'b0;
      selective_wake_armed_o <= 1'b0;
    end else begin
      wake_config_valid_o    <= valid_reg;
      selective_wake_armed_o <= valid_reg && selective_wake_enable_i;
    end
  end

  // trim status and reference; the reference only passes while trimming,
  // so idle bus traffic cannot disturb the oscillator
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      osc_trim_active_o <= 1'b0;
      trim_ref_o        <= 1'b0;
    end else begin
      osc_trim_active_o <= trim_mode_reg && unlocked;
      trim_ref_o        <= trim_mode_reg && unlocked && bus_transmit_data_pin_i;
    end
  end

  // option register write gate, one pulse per request
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      opt_wr_allow_o <= 1'b0;
    end else begin
      opt_wr_allow_o <= opt_wr_req_i && unlocked;
    end
  end

  // time-out status and interrupt level; the mask only gates the pin,
  // the status flag still shows the event
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      bus_timeout_flag_o <= 1'b0;
      irq_o              <= 1'b0;
    end else begin
      bus_timeout_flag_o <= to_flag_reg;
      irq_o              <= to_flag_reg && toie_reg;
    end
  end

  // standard frames compare only the top eleven id bits
  always_comb begin
    cmp_mask = '1;
    if (!ide_reg) begin
      cmp_mask = '0;
      cmp_mask[`SWCFG_STD_ID_HI:`SWCFG_STD_ID_LO] = '1;
    end
  end

  // per-bit identifier compare; bits outside the mask always agree
  for (genvar i = 0; i < $bits(swcfg_id_type); i++) begin : g_id_bit
    assign id_bit_ok[i] = !cmp_mask[i] || (rx_id_i[i] == id_full[i]);
  end

  // configuration view for the frame decoder
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      quanta_per_bit_o <= `SWCFG_RST_QUANTA;
      sample_point_o   <= `SWCFG_RST_SAMPLE;
      wake_id_o        <= '0;
      wake_rtr_o       <= 1'b0;
      wake_ide_o       <= 1'b0;
    end else begin
      quanta_per_bit_o <= quanta_reg;
      sample_point_o   <= sample_reg;
      wake_id_o        <= id_full;
      wake_rtr_o       <= rtr_reg;
      wake_ide_o       <= ide_reg;
    end
  end

  // id compare result, a pulse one cycle after the received frame
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      id_match_o <= 1'b0;
    end else begin
      id_match_o <= rx_frame_valid_i
                    && (&id_bit_ok)
                    && (rx_ide_i == ide_reg)
                    && (rx_rtr_i == rtr_reg);
    end
  end

endmodule
`default_nettype wire

/* swcfg_host.sv */
// host model on the register port: writes, reads and the trim reference pin
`timescale 1ns/10ps
`default_nettype none
module swcfg_host (
  input  wire logic                      clk_i,
  input  wire logic                      rvalid_i,
  input  wire swcfg_pkg::swcfg_byte_type rdata_i,
  output logic                           wr_o,
  output logic                           rd_o,
  output swcfg_pkg::swcfg_addr_type      addr_o,
  output swcfg_pkg::swcfg_byte_type      wdata_o,
  output logic                           pin_o
);
  import swcfg_pkg::*;
  initial begin
    {wr_o, rd_o, pin_o, addr_o, wdata_o} = 18'h0;
  end
  // held over one rising edge, then inverted so no stale value lingers
  task automatic wr(input swcfg_addr_type a, input swcfg_byte_type d);
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  // data taken while the one-cycle valid pulse stands
  task automatic rd(input swcfg_addr_type a, output swcfg_byte_type d);
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b0, ~a};
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask
  // valid flag last, since any data write clears it
  task automatic arm(input logic [10:0] id);
    wr(7'h23, id[10:3]);
    wr(7'h24, {id[2:0], 5'h00});
    wr(7'h25, 8'h00);
    wr(7'h26, 8'h00);
    wr(7'h20, 8'h01);
  endtask
  // trim reference level on the transmit-data pin
  task automatic ref_bit(input logic b);
    @(negedge clk_i);
    pin_o = b;
  endtask
endmodule
`default_nettype wire

/* swcfg_regs_asserts.sv */
// assertion checker for the selective-wake register set
`timescale 1ns/10ps
`default_nettype none
module swcfg_regs_asserts (
  input wire logic                      sys_clk_i,
  input wire logic                      rst_b_i,
  input wire logic                      soft_reset_i,
  input wire logic                      reg_wr_i,
  input wire logic                      reg_rd_i,
  input wire swcfg_pkg::swcfg_addr_type reg_addr_i,
  input wire swcfg_pkg::swcfg_byte_type reg_wdata_i,
  input wire logic                      reg_rdata_valid_o,
  input wire swcfg_pkg::swcfg_byte_type reg_rdata_o,
  input wire logic                      stop_mode_i,
  input wire logic                      wake_event_i,
  input wire logic                      selective_wake_enable_i,
  input wire logic                      opt_wr_req_i,
  input wire logic                      wake_config_valid_o,
  input wire logic                      osc_trim_active_o,
  input wire logic                      opt_wr_allow_o,
  input wire logic                      bus_timeout_flag_o,
  input wire logic                      irq_o
);
  import swcfg_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  swcfg_byte_type ctl_reg;
  logic           unlk;
  // shadow of the control byte, its stored fields are not at the ports
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || soft_reset_i) begin
      ctl_reg <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == 7'h20) begin
      ctl_reg <= reg_wdata_i;
    end
  end
  assign unlk = ctl_reg[6:5] == 2'h3;
  property p_wake; wake_event_i |-> ##2 !wake_config_valid_o; endproperty
  a_wake: assert property (p_wake) else $error("valid kept after wake");
  property p_data;
    reg_wr_i && reg_addr_i inside {[7'h21:7'h26]} |-> ##2 !wake_config_valid_o;
  endproperty
  a_data: assert property (p_data) else $error("valid kept after data write");
  property p_stop;
    stop_mode_i && reg_wr_i && reg_addr_i == 7'h20 |-> ##2 !wake_config_valid_o;
  endproperty
  a_stop: assert property (p_stop) else $error("valid set in stop mode");
  property p_rsv;
    reg_rd_i && reg_addr_i == 7'h20 |=> reg_rdata_valid_o && reg_rdata_o[3:1] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("unused control bits read");
  property p_opt; opt_wr_req_i |=> opt_wr_allow_o == $past(unlk); endproperty
  a_opt: assert property (p_opt) else $error("option write gate wrong");
  property p_irq; irq_o == (bus_timeout_flag_o && $past(ctl_reg[4])); endproperty
  a_irq: assert property (p_irq) else $error("interrupt mask wrong");
  property p_trim; !$past(ctl_reg[7]) |-> !osc_trim_active_o; endproperty
  a_trim: assert property (p_trim) else $error("trim active while off");
  property p_tof; !selective_wake_enable_i |=> ##1 $stable(bus_timeout_flag_o); endproperty
  a_tof: assert property (p_tof) else $error("flag moved while disabled");
  c_arm: cover property (wake_config_valid_o);
  c_irq: cover property (irq_o);
  c_opt: cover property (opt_wr_allow_o);
endmodule
bind swcfg_regs swcfg_regs_asserts swcfg_regs_asserts_i (.*);
`default_nettype wire

/* can_selective_wake_config_bench.sv */
// self-checking bench for the selective-wake register set
`timescale 1ns/10ps
`default_nettype none
module can_selective_wake_config_bench;
  import swcfg_pkg::*;
  logic             sys_clk_i, rst_b_i, soft_reset_i, stop_mode_i, bus_cfg_wr_i;
  logic             wake_event_i, selective_wake_enable_i, opt_wr_req_i, rx_rtr_i;
  logic             bus_timeout_event_i, bus_timeout_clear_i, rx_frame_valid_i, rx_ide_i;
  logic             reg_wr_i, reg_rd_i, bus_transmit_data_pin_i, reg_rdata_valid_o;
  logic             wake_config_valid_o, selective_wake_armed_o, osc_trim_active_o;
  logic             trim_ref_o, opt_wr_allow_o, bus_timeout_flag_o, irq_o;
  logic             wake_rtr_o, wake_ide_o, id_match_o;
  swcfg_addr_type   reg_addr_i;
  swcfg_byte_type   reg_wdata_i, reg_rdata_o, quanta_per_bit_o, rd_v;
  swcfg_sample_type sample_point_o;
  swcfg_id_type     rx_id_i, wake_id_o;
  int               n_fail, n_tests;
  swcfg_regs swcfg_regs_i (.*);
  swcfg_host swcfg_host_i (.clk_i(sys_clk_i), .rvalid_i(reg_rdata_valid_o),
    .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .pin_o(bus_transmit_data_pin_i));
  // 50 ns period
  always #25 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string nm, input logic [28:0] e, input logic [28:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask
  // one received frame; the match pulse is looked at while it stands
  task automatic frame(input swcfg_id_type id, input logic ide, input logic rtr,
                       input logic e);
    @(negedge sys_clk_i);
    {rx_id_i, rx_ide_i, rx_rtr_i, rx_frame_valid_i} = {id, ide, rtr, 1'b1};
    @(negedge sys_clk_i);
    rx_frame_valid_i = 1'b0;
    chk("match", e, id_match_o);
  endtask
  task automatic rdchk(input swcfg_addr_type a, input swcfg_byte_type e);
    swcfg_host_i.rd(a, rd_v);
    chk("rdata", e, rd_v);
  endtask
  task automatic t_dflt();
    swcfg_byte_type d [7] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rdchk(7'h20 + 7'(i), d[i]);
    end
    rdchk(7'h27, 8'h00);
    chk("quanta", 8'ha0, quanta_per_bit_o);
    chk("sample", 6'h33, sample_point_o);
  endtask
  // reserved bits dropped, fields reach the outputs, soft reset restores
  task automatic t_rw();
    swcfg_byte_type w [7] = '{8'hfe, 8'h5a, 8'hff, 8'hc3, 8'h96, 8'h3c, 8'hff};
    swcfg_byte_type e [7] = '{8'hf0, 8'h5a, 8'h3f, 8'hc3, 8'h96, 8'h3c, 8'h7f};
    for (int i = 0; i < 7; i++) begin
      swcfg_host_i.wr(7'h20 + 7'(i), w[i]);
    end
    for (int i = 0; i < 7; i++) begin
      rdchk(7'h20 + 7'(i), e[i]);
    end
    chk("id", {8'hc3, 8'h96, 8'h3c, 5'h1f}, wake_id_o);
    chk("flags", 2'h3, {wake_rtr_o, wake_ide_o});
    chk("quanta", 8'h5a, quanta_per_bit_o);
    chk("sample", 6'h3f, sample_point_o);
    @(negedge sys_clk_i);
    soft_reset_i = 1'b1;
    @(negedge sys_clk_i);
    soft_reset_i = 1'b0;
    t_dflt();
  endtask
  // every unlock code, then trim bit on and off with the pin toggling
  task automatic t_unlk();
    for (int u = 0; u < 4; u++) begin
      swcfg_host_i.wr(7'h20, {1'b1, 2'(u), 5'h00});
      @(negedge sys_clk_i);
      opt_wr_req_i = 1'b1;
      @(negedge sys_clk_i);
      opt_wr_req_i = 1'b0;
      chk("allow", u == 3, opt_wr_allow_o);
    end
    chk("trim", 1'b1, osc_trim_active_o);
    for (int b = 1; b >= 0; b--) begin
      swcfg_host_i.ref_bit(b[0]);
      step();
      step();
      chk("ref", b[0], trim_ref_o);
    end
    swcfg_host_i.wr(7'h20, 8'h60);
    swcfg_host_i.ref_bit(1'b1);
    step();
    chk("trim", 1'b0, osc_trim_active_o);
    chk("ref", 1'b0, trim_ref_o);
  endtask
  // flag frozen without wake enable; interrupt needs its enable bit
  task automatic t_to();
    for (int k = 0; k < 3; k++) begin
      swcfg_host_i.wr(7'h20, {3'h0, k == 2, 4'h0});
      @(negedge sys_clk_i);
      selective_wake_enable_i = k != 0;
      bus_timeout_event_i = 1'b1;
      @(negedge sys_clk_i);
      bus_timeout_event_i = 1'b0;
      step();
      chk("flag", k != 0, bus_timeout_flag_o);
      chk("irq", k == 2, irq_o);
      @(negedge sys_clk_i);
      bus_timeout_clear_i = 1'b1;
      @(negedge sys_clk_i);
      bus_timeout_clear_i = 1'b0;
      step();
      chk("flag", 1'b0, bus_timeout_flag_o);
    end
  endtask
  // arm, compare ids, then each disturbance must drop the valid flag
  task automatic t_val();
    swcfg_host_i.arm(11'h5a5);
    step();
    chk("valid", 2'h3, {wake_config_valid_o, selective_wake_armed_o});
    chk("flags", 2'h0, {wake_rtr_o, wake_ide_o});
    @(negedge sys_clk_i);
    selective_wake_enable_i = 1'b0;
    step();
    chk("armed", 1'b0, selective_wake_armed_o);
    @(negedge sys_clk_i);
    selective_wake_enable_i = 1'b1;
    frame({11'h5a5, 18'h2_abcd}, 1'b0, 1'b0, 1'b1);
    frame({11'h5a4, 18'h2_abcd}, 1'b0, 1'b0, 1'b0);
    frame({11'h5a5, 18'h0_0000}, 1'b0, 1'b1, 1'b0);
    frame({11'h5a5, 18'h0_0000}, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      swcfg_host_i.arm(11'h5a5);
      @(negedge sys_clk_i);
      stop_mode_i = k == 2;
      wake_event_i = k == 1;
      bus_cfg_wr_i = k == 2;
      @(negedge sys_clk_i);
      {wake_event_i, bus_cfg_wr_i} = 2'h0;
      if (k == 0) swcfg_host_i.wr(7'h21, 8'ha0);
      step();
      chk("valid", 1'b0, wake_config_valid_o);
    end
    swcfg_host_i.wr(7'h20, 8'h01);
    step();
    chk("valid", 1'b0, wake_config_valid_o);
    // extended format compares all 29 bits, the lowest included
    swcfg_host_i.wr(7'h26, 8'h05);
    frame({8'hb4, 8'ha0, 8'h00, 5'h01}, 1'b1, 1'b0, 1'b1);
    frame({8'hb4, 8'ha0, 8'h00, 5'h00}, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic results();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {sys_clk_i, rst_b_i, soft_reset_i, stop_mode_i, bus_cfg_wr_i, wake_event_i} = 6'h0;
    {selective_wake_enable_i, opt_wr_req_i, rx_rtr_i, rx_ide_i} = 4'h0;
    {bus_timeout_event_i, bus_timeout_clear_i, rx_frame_valid_i, rx_id_i} = 32'h0;
    repeat (10) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    t_dflt();
    t_rw();
    t_unlk();
    t_to();
    t_val();
    results();
  end
  // watchdog far beyond the few hundred cycles needed
  initial begin
    #1_000_000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
